// ---- rtl/ald_alu.sv ----
// Combinational arithmetic and logic unit
`timescale 1ns/1ps
`default_nettype none

module ald_alu (
   // Operands and results
   ald_alu_if.alu port
);
   import ald_pkg::*;

   logic [31:0] addA;
   logic [31:0] addB;
   logic addCin;
   logic [32:0] sum;

   // ==========================================
   // Adder operand selection
   always_comb begin
      addA = port.opA;
      addB = port.opB;
      addCin = 1'b0;
      unique case (port.op)
         ADD_CARRY_FLAGSET: addCin = port.carryIn;
         MINUS_OP, MINUS_FLAGGED: begin
            addB = ~port.opB;
            addCin = 1'b1;
         end
         MINUS_CARRY: begin
            addB = ~port.opB;
            addCin = ~port.carryIn;
         end
         NEGATE_OP: begin
            addA = 32'h0000_0000;
            addB = ~port.opA;
            addCin = 1'b1;
         end
         default: addCin = 1'b0;
      endcase
   end

   assign sum = ald_add33(addA, addB, addCin);

   // ==========================================
   // Result and flag update selection
   always_comb begin
      port.result = 32'h0000_0000;
      port.updNz = 1'b0;
      port.updCv = 1'b0;
      port.known = 1'b1;
      unique case (port.op)
         SUM_OP, MINUS_OP: port.result = sum[31:0];
         SUM_FLAGGED, MINUS_FLAGGED, ADD_CARRY_FLAGSET, MINUS_CARRY, NEGATE_OP: begin
            port.result = sum[31:0];
            port.updNz = 1'b1;
            port.updCv = 1'b1;
         end
         CONJ_OP: begin
            port.result = port.opA & port.opB;
            port.updNz = 1'b1;
         end
         XOR_OP: begin
            port.result = port.opA ^ port.opB;
            port.updNz = 1'b1;
         end
         DISJ_OP: begin
            port.result = port.opA | port.opB;
            port.updNz = 1'b1;
         end
         CLEAR_BITS_OP: begin
            port.result = port.opA & ~port.opB;
            port.updNz = 1'b1;
         end
         SWAP_HALF_SIGNED: port.result = {{16{port.opA[7]}}, port.opA[7:0], port.opA[15:8]};
         default: port.known = 1'b0;
      endcase
   end

   // ==========================================
   // Flag values
   always_comb begin
      port.flagsOut.neg = port.result[31];
      port.flagsOut.zero = (port.result == 32'h0000_0000);
      port.flagsOut.carry = sum[32];
      port.flagsOut.ovf = ald_ovf(addA, addB, sum[31:0]);
   end

endmodule : ald_alu

`default_nettype wire

// ---- rtl/ald_alu_if.sv ----
// Operand and result bundle between sequencer and arithmetic unit
`timescale 1ns/1ps
`default_nettype none

interface ald_alu_if;
   import ald_pkg::*;
   ald_op_type op;
   logic [31:0] opA;
   logic [31:0] opB;
   logic carryIn;
   logic [31:0] result;
   ald_flags_type flagsOut;
   logic updNz;
   logic updCv;
   logic known;

   modport core (output op, output opA, output opB, output carryIn,
                 input result, input flagsOut, input updNz, input updCv, input known);
   modport alu (input op, input opA, input opB, input carryIn,
                output result, output flagsOut, output updNz, output updCv, output known);
endinterface : ald_alu_if

`default_nettype wire

// ---- rtl/ald_datapath.sv ----
// Arithmetic and logic datapath top with register file and register port
//
// How it works
// - Add with carry adds both sources plus carry, writes back, sets all four flags.
// - Plain add leaves flags; flagged add is the same sum and sets all four flags.
// - Plain subtract leaves flags; flagged subtract also sets all four flags.
// - Negate subtracts the first source from zero and sets all four flags.
// - Subtract with carry removes one more when carry is set; sets all flags.
// - With no destination given, the result goes to the first source register.
// - AND, exclusive OR and inclusive OR combine both sources into the destination.
// - Bit clear Conj_op first source with the inverse of the second source.
// - Logic operations set negative and zero, keep carry and overflow.
// - Swap-half reverses the bottom halfword bytes and sign extends to a word.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ald_defs.svh"

module ald_datapath #(
   parameter int DATA_W = 32,
   parameter int REG_COUNT = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Operation request
   input wire logic opValid,
   output logic opReady,
   input wire ald_pkg::ald_op_type opCode,
   input wire logic [3:0] firstReg,
   input wire logic [3:0] secondReg,
   input wire logic [3:0] dstReg,
   input wire logic dstOmit,
   input wire logic useImm,
   input wire logic [31:0] immValue,
   // Operation answer
   output logic resultValid,
   output logic [31:0] resultData,
   output logic [3:0] resultDst,
   output logic opIllegal,
   // Condition flags
   output logic flagNeg,
   output logic flagZero,
   output logic flagCarry,
   output logic flagOvf,
   // Register port
   input wire logic [`ALD_ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData
);
   import ald_pkg::*;

   if (DATA_W != 32 || REG_COUNT != 16) begin : g_chk
      $error("ald_datapath: only a 32-bit datapath with 16 registers is supported");
   end

   if (`ALD_FLAG_N_BIT != 3 || `ALD_FLAG_Z_BIT != 2 || `ALD_FLAG_C_BIT != 1 || `ALD_FLAG_V_BIT != 0) begin : g_flag_chk
      $error("ald_datapath: flag positions must follow the packed flags type");
   end

   if (`ALD_FILE_LAST != `ALD_FILE_BASE + 4 * (REG_COUNT - 1)) begin : g_map_chk
      $error("ald_datapath: register file window must hold REG_COUNT words");
   end

   // ==========================================
   // Address decode helpers
   function automatic logic ald_is_file(input logic [`ALD_ADDR_W-1:0] addr);
      return (addr >= `ALD_FILE_BASE) && (addr <= `ALD_FILE_LAST) && (addr[1:0] == 2'h0);
   endfunction : ald_is_file

   function automatic logic [3:0] ald_file_index(input logic [`ALD_ADDR_W-1:0] addr);
      return addr[5:2];
   endfunction : ald_file_index

   function automatic logic ald_is_flags(input logic [`ALD_ADDR_W-1:0] addr);
      return addr == `ALD_FLAGS_ADDR;
   endfunction : ald_is_flags

   function automatic logic ald_is_status(input logic [`ALD_ADDR_W-1:0] addr);
      return addr == `ALD_STATUS_ADDR;
   endfunction : ald_is_status

   // ==========================================
   // Declarations
   ald_state_type state_ff;
   ald_state_type nxt_state;
   ald_op_type cmdOp_ff;
   logic [3:0] cmdDst_ff;
   logic cmdUseImm_ff;
   logic [31:0] cmdImm_ff;
   ald_flags_type flags_ff;
   ald_flags_type nxt_flags;
   logic resultValid_ff;
   logic [31:0] resultData_ff;
   logic [3:0] resultDst_ff;
   logic opIllegal_ff;
   logic lastIllegal_ff;
   ald_rdsel_type rdSel_ff;
   logic [31:0] rdWord_ff;
   logic opTake;
   logic execDone;
   logic writeBack;
   logic busFileWr;
   logic busFlagsWr;
   logic [3:0] takeDst;
   logic [31:0] rfA;
   logic [31:0] rfB;
   logic [31:0] rfS;
   logic [31:0] localWord;

   ald_alu_if aluBus();

   // ==========================================
   // Request handshake
   assign opReady = (state_ff == ST_IDLE);
   assign opTake = opValid && opReady;
   assign execDone = (state_ff == ST_EXEC);
   assign writeBack = execDone && aluBus.known;
   assign takeDst = dstOmit ? firstReg : dstReg;

   // ==========================================
   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (opTake) begin
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================
   // Command capture
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmdOp_ff <= SUM_OP;
         cmdDst_ff <= 4'h0;
         cmdUseImm_ff <= 1'b0;
         cmdImm_ff <= 32'h0000_0000;
      end else if (opTake) begin
         cmdOp_ff <= opCode;
         cmdDst_ff <= takeDst;
         cmdUseImm_ff <= useImm;
         cmdImm_ff <= immValue;
      end
   end

   // ==========================================
   // Register file
   assign busFileWr = regWrStb && ald_is_file(regAddr);
   assign busFlagsWr = regWrStb && ald_is_flags(regAddr);

   ald_regfile #(
      .WIDTH(DATA_W),
      .DEPTH(REG_COUNT)
   ) u_regfile (
      .clk(sys_clk),
      .rst(sys_rst),
      .rdAddrA(firstReg),
      .rdAddrB(secondReg),
      .rdAddrS(ald_file_index(regAddr)),
      .rdDataA(rfA),
      .rdDataB(rfB),
      .rdDataS(rfS),
      .wrEnC(writeBack),
      .wrAddrC(cmdDst_ff),
      .wrDataC(aluBus.result),
      .wrEnS(busFileWr),
      .wrAddrS(ald_file_index(regAddr)),
      .wrDataS(regWrData)
   );

   // ==========================================
   // Arithmetic unit
   assign aluBus.op = cmdOp_ff;
   assign aluBus.opA = rfA;
   assign aluBus.opB = cmdUseImm_ff ? cmdImm_ff : rfB;
   assign aluBus.carryIn = flags_ff.carry;

   ald_alu u_alu (
      .port(aluBus.alu)
   );

   // ==========================================
   // Flags, operation update wins over a software write
   always_comb begin
      nxt_flags = flags_ff;
      if (busFlagsWr) begin
         nxt_flags = ald_flags_type'(regWrData[`ALD_FLAGS_W-1:0]);
      end
      if (writeBack && aluBus.updNz) begin
         nxt_flags.neg = aluBus.flagsOut.neg;
         nxt_flags.zero = aluBus.flagsOut.zero;
      end
      if (writeBack && aluBus.updCv) begin
         nxt_flags.carry = aluBus.flagsOut.carry;
         nxt_flags.ovf = aluBus.flagsOut.ovf;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_ff <= ald_flags_type'(`ALD_FLAGS_RST);
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   assign flagNeg = flags_ff.neg;
   assign flagZero = flags_ff.zero;
   assign flagCarry = flags_ff.carry;
   assign flagOvf = flags_ff.ovf;

   // ==========================================
   // Operation answer
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         resultValid_ff <= 1'b0;
         opIllegal_ff <= 1'b0;
      end else begin
         resultValid_ff <= execDone;
         opIllegal_ff <= execDone && !aluBus.known;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         resultData_ff <= 32'h0000_0000;
         resultDst_ff <= 4'h0;
      end else if (writeBack) begin
         resultData_ff <= aluBus.result;
         resultDst_ff <= cmdDst_ff;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lastIllegal_ff <= 1'b0;
      end else if (execDone) begin
         lastIllegal_ff <= !aluBus.known;
      end
   end

   assign resultValid = resultValid_ff;
   assign resultData = resultData_ff;
   assign resultDst = resultDst_ff;
   assign opIllegal = opIllegal_ff;

   // ==========================================
   // Register port reads
   always_comb begin
      localWord = 32'h0000_0000;
      if (ald_is_flags(regAddr)) begin
         localWord[`ALD_FLAGS_W-1:0] = flags_ff;
      end else if (ald_is_status(regAddr)) begin
         localWord[`ALD_ST_BUSY_BIT] = (state_ff == ST_EXEC);
         localWord[`ALD_ST_ILL_BIT] = lastIllegal_ff;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdSel_ff <= RD_NONE;
         rdWord_ff <= 32'h0000_0000;
      end else begin
         rdWord_ff <= localWord;
         if (!regRdStb) begin
            rdSel_ff <= RD_NONE;
         end else if (ald_is_file(regAddr)) begin
            rdSel_ff <= RD_FILE;
         end else begin
            rdSel_ff <= RD_LOCAL;
         end
      end
   end

   always_comb begin
      unique case (rdSel_ff)
         RD_FILE: regRdData = rfS;
         RD_LOCAL: regRdData = rdWord_ff;
         default: regRdData = 32'h0000_0000;
      endcase
   end

endmodule : ald_datapath

`default_nettype wire

// ---- rtl/ald_defs.svh ----
// Offsets, field positions and reset values of the datapath
`ifndef ALD_DEFS_SVH
`define ALD_DEFS_SVH

// ==========================================
// Register port addresses (byte addresses)
`define ALD_ADDR_W 8
`define ALD_FILE_BASE 8'h00
`define ALD_FILE_LAST 8'h3C
`define ALD_FLAGS_ADDR 8'h40
`define ALD_STATUS_ADDR 8'h44

// ==========================================
// Flags word fields
`define ALD_FLAGS_W 4
`define ALD_FLAG_N_BIT 3
`define ALD_FLAG_Z_BIT 2
`define ALD_FLAG_C_BIT 1
`define ALD_FLAG_V_BIT 0
`define ALD_FLAGS_RST 4'h0

// ==========================================
// Status word fields
`define ALD_ST_BUSY_BIT 0
`define ALD_ST_ILL_BIT 1

`endif

// ---- rtl/ald_pkg.sv ----
// Types and shared arithmetic of the datapath
package ald_pkg;

   // ==========================================
   // Operations
   typedef enum logic [3:0] {
      SUM_OP,
      SUM_FLAGGED,
      ADD_CARRY_FLAGSET,
      MINUS_OP,
      MINUS_FLAGGED,
      MINUS_CARRY,
      NEGATE_OP,
      CONJ_OP,
      XOR_OP,
      DISJ_OP,
      CLEAR_BITS_OP,
      SWAP_HALF_SIGNED
   } ald_op_type;

   // ==========================================
   // Sequencer and read source
   typedef enum logic {ST_IDLE, ST_EXEC} ald_state_type;
   typedef enum logic [1:0] {RD_NONE, RD_FILE, RD_LOCAL} ald_rdsel_type;

   // ==========================================
   // Flags, high bit first
   typedef struct packed {
      logic neg;
      logic zero;
      logic carry;
      logic ovf;
   } ald_flags_type;

   // ==========================================
   // Adder helpers
   function automatic logic [32:0] ald_add33(input logic [31:0] a, input logic [31:0] b, input logic cin);
      return {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
   endfunction : ald_add33

   function automatic logic ald_ovf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
      return (a[31] == b[31]) && (s[31] != a[31]);
   endfunction : ald_ovf

endpackage : ald_pkg

// ---- rtl/ald_regfile.sv ----
// Register file memory with registered read ports
`timescale 1ns/1ps
`default_nettype none

module ald_regfile #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Read ports
   input wire logic [$clog2(DEPTH)-1:0] rdAddrA,
   input wire logic [$clog2(DEPTH)-1:0] rdAddrB,
   input wire logic [$clog2(DEPTH)-1:0] rdAddrS,
   output logic [WIDTH-1:0] rdDataA,
   output logic [WIDTH-1:0] rdDataB,
   output logic [WIDTH-1:0] rdDataS,
   // Write ports, core wins on the same word
   input wire logic wrEnC,
   input wire logic [$clog2(DEPTH)-1:0] wrAddrC,
   input wire logic [WIDTH-1:0] wrDataC,
   input wire logic wrEnS,
   input wire logic [$clog2(DEPTH)-1:0] wrAddrS,
   input wire logic [WIDTH-1:0] wrDataS
);

   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("ald_regfile: DEPTH must be at least 2 and WIDTH at least 1");
   end

   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================
   // Writes
   always_ff @(posedge clk) begin
      if (wrEnS) begin
         mem[wrAddrS] <= wrDataS;
      end
      if (wrEnC) begin
         mem[wrAddrC] <= wrDataC;
      end
   end

   // ==========================================
   // Registered reads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdDataA <= '0;
         rdDataB <= '0;
         rdDataS <= '0;
      end else begin
         rdDataA <= mem[rdAddrA];
         rdDataB <= mem[rdAddrB];
         rdDataS <= mem[rdAddrS];
      end
   end

endmodule : ald_regfile

`default_nettype wire

// ---- tb/ald_datapath_monitor.sv ----
// Port checker for the arithmetic and logic datapath
`timescale 1ns/1ps
`default_nettype none

module ald_datapath_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Operation request
   input wire logic opValid,
   input wire logic opReady,
   input wire ald_pkg::ald_op_type opCode,
   input wire logic [3:0] firstReg,
   input wire logic [3:0] dstReg,
   input wire logic dstOmit,
   // Operation answer
   input wire logic resultValid,
   input wire logic [31:0] resultData,
   input wire logic [3:0] resultDst,
   // Condition flags
   input wire logic flagNeg,
   input wire logic flagZero,
   input wire logic flagCarry,
   input wire logic flagOvf
);
   import ald_pkg::*;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   logic take;
   assign take = opValid && opReady;

   // ==========================================
   // Assertions
   AST_TAKE_TIMING: assert property (take |=> !opReady && !resultValid ##1 opReady && resultValid)
      else $error("answer timing wrong");
   AST_ARITH_NZ: assert property (take && opCode inside {SUM_FLAGGED, ADD_CARRY_FLAGSET, MINUS_FLAGGED,
      MINUS_CARRY, NEGATE_OP} |-> ##2 flagZero == (resultData == 32'h0000_0000) && flagNeg == resultData[31])
      else $error("arithmetic negative or zero flag wrong");
   AST_PLAIN_KEEPS: assert property (take && opCode inside {SUM_OP, MINUS_OP, SWAP_HALF_SIGNED}
      |-> ##2 $stable({flagNeg, flagZero, flagCarry, flagOvf}))
      else $error("plain operation changed flags");
   AST_LOGIC_FLAGS: assert property (take && opCode inside {CONJ_OP, XOR_OP, DISJ_OP, CLEAR_BITS_OP}
      |-> ##2 $stable({flagCarry, flagOvf}) && flagZero == (resultData == 32'h0000_0000))
      else $error("logic operation flags wrong");
   AST_NEG_CV: assert property (take && opCode == NEGATE_OP |-> ##2
      flagCarry == (resultData == 32'h0000_0000) && flagOvf == (resultData == 32'h8000_0000))
      else $error("negate carry or overflow wrong");
   AST_SWAP_SEXT: assert property (take && opCode == SWAP_HALF_SIGNED |-> ##2
      resultData[31:16] == {16{resultData[15]}})
      else $error("swap half not sign extended");
   AST_OMIT_DST: assert property (take && dstOmit && opCode <= SWAP_HALF_SIGNED |-> ##2
      resultDst == $past(firstReg, 2))
      else $error("omitted destination not first source");
   AST_GIVEN_DST: assert property (take && !dstOmit && opCode <= SWAP_HALF_SIGNED |-> ##2
      resultDst == $past(dstReg, 2))
      else $error("destination register wrong");

   // ==========================================
   // Coverage
   cover property (take && opCode == MINUS_CARRY);
   cover property (resultValid && take);
   cover property (take && dstOmit && opCode == CLEAR_BITS_OP);
endmodule : ald_datapath_monitor

bind ald_datapath ald_datapath_monitor u_mon (.sys_clk, .sys_rst, .opValid, .opReady, .opCode, .firstReg,
   .dstReg, .dstOmit, .resultValid, .resultData, .resultDst, .flagNeg, .flagZero, .flagCarry, .flagOvf);

`default_nettype wire

// ---- tb/ald_datapath_tb.sv ----
// Self-checking testbench of the arithmetic and logic datapath
`timescale 1ns/1ps
`default_nettype none
`include "ald_defs.svh"

module ald_datapath_tb;
   import ald_pkg::*;

   logic sys_clk, sys_rst, opValid, opReady, dstOmit, useImm, resultValid, opIllegal;
   logic flagNeg, flagZero, flagCarry, flagOvf, regWrStb, regRdStb, om, im, gotIll;
   ald_op_type opCode, o;
   logic [3:0] firstReg, secondReg, dstReg, resultDst, gotFlags, gotDst;
   logic [31:0] immValue, resultData, regWrData, regRdData, rd, gotData;
   logic [7:0] regAddr;
   logic [35:0] e;
   int mismatches, checked;
   logic [31:0] opsA [4] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_0000, 32'h1234_80F0};
   logic [31:0] opsB [4] = '{32'h0000_0001, 32'h8000_0000, 32'h0000_00FF, 32'hFFFF_0F0F};

   ald_datapath u_dut (.sys_clk, .sys_rst, .opValid, .opReady, .opCode, .firstReg, .secondReg, .dstReg,
      .dstOmit, .useImm, .immValue, .resultValid, .resultData, .resultDst, .opIllegal, .flagNeg, .flagZero,
      .flagCarry, .flagOvf, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData);
   ald_issuer u_iss (.sys_clk, .opReady, .opValid, .opCode, .firstReg, .secondReg, .dstReg, .dstOmit,
      .useImm, .immValue);

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ==========================================
   // Checks and closing
   task automatic chkWord(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chkWord

   task automatic chkNib(input string what, input logic [3:0] exp, got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chkNib

   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   // ==========================================
   // Register port and operation tasks
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
      @(posedge sys_clk);
   endtask : regWrite

   task automatic regRead(input logic [7:0] a, output logic [31:0] d);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1;
      d = regRdData;
      @(posedge sys_clk);
   endtask : regRead

   task automatic runOp(input ald_op_type op, input logic [3:0] f, s, d, input logic om, im,
                        input logic [31:0] iv, input int gap);
      int n;
      u_iss.issue(op, f, s, d, om, im, iv, gap);
      u_iss.idle();
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (resultValid !== 1'b1 && n < 8);
      if (n >= 8 || u_iss.timedOut) begin
         mismatches++;
         test_done();
      end
      gotData = resultData;
      gotDst = resultDst;
      gotFlags = {flagNeg, flagZero, flagCarry, flagOvf};
      gotIll = opIllegal;
      @(posedge sys_clk);
   endtask : runOp

   // Expected flags and result
   function automatic logic [35:0] expOp(input ald_op_type op, input logic [31:0] a, b, input logic [3:0] f);
      logic [31:0] aa, bb, r;
      logic [32:0] s;
      logic ci;
      logic [3:0] nf;
      nf = f;
      aa = (op == NEGATE_OP) ? 32'h0000_0000 : a;
      bb = (op == NEGATE_OP) ? ~a : (op inside {MINUS_OP, MINUS_FLAGGED, MINUS_CARRY}) ? ~b : b;
      ci = (op == ADD_CARRY_FLAGSET) ? f[1] : (op == MINUS_CARRY) ? ~f[1] :
           (op inside {MINUS_OP, MINUS_FLAGGED, NEGATE_OP});
      s = {1'b0, aa} + {1'b0, bb} + {32'h0000_0000, ci};
      r = s[31:0];
      case (op)
         CONJ_OP: r = a & b;
         XOR_OP: r = a ^ b;
         DISJ_OP: r = a | b;
         CLEAR_BITS_OP: r = a & ~b;
         SWAP_HALF_SIGNED: r = {{16{a[7]}}, a[7:0], a[15:8]};
         default: ;
      endcase
      if (op inside {CONJ_OP, XOR_OP, DISJ_OP, CLEAR_BITS_OP})
         nf = {r[31], r == 32'h0000_0000, f[1:0]};
      else if (!(op inside {SUM_OP, MINUS_OP, SWAP_HALF_SIGNED}))
         nf = {r[31], r == 32'h0000_0000, s[32], (aa[31] == bb[31]) && (r[31] != aa[31])};
      return {nf, r};
   endfunction : expOp

   // ==========================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      mismatches = 0;
      checked = 0;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      regRead(`ALD_FLAGS_ADDR, rd);
      chkWord("flags after reset", 32'h0000_0000, rd);
      regRead(8'h80, rd);
      chkWord("unmapped", 32'h0000_0000, rd);
      for (int op = 0; op < 12; op++) begin
         for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 2; c++) begin
               o = ald_op_type'(op);
               om = (k == 2) || !(o inside {SUM_FLAGGED, MINUS_FLAGGED, NEGATE_OP, SWAP_HALF_SIGNED});
               im = (k == 2) && (o inside {SUM_FLAGGED, MINUS_FLAGGED});
               regWrite(8'h04, opsA[k]);
               regWrite(8'h08, im ? ~opsB[k] : opsB[k]);
               regWrite(`ALD_FLAGS_ADDR, {28'h0000000, {4{c[0]}}});
               e = expOp(o, opsA[k], opsB[k], {4{c[0]}});
               runOp(o, 4'h1, 4'h2, 4'h3, om, im, opsB[k], k);
               chkWord("result", e[31:0], gotData);
               chkNib("flags", e[35:32], gotFlags);
               chkNib("dest id", om ? 4'h1 : 4'h3, gotDst);
               chkNib("illegal", 4'h0, {3'b000, gotIll});
               regRead(om ? 8'h04 : 8'h0C, rd);
               chkWord("dest reg", e[31:0], rd);
            end
         end
      end
      regWrite(8'h10, 32'hFFFF_FFFF);
      regWrite(8'h14, 32'h0000_0001);
      regWrite(8'h18, 32'h0000_0000);
      regWrite(8'h1C, 32'h0000_0000);
      u_iss.issue(SUM_FLAGGED, 4'h4, 4'h5, 4'h4, 1'b1, 1'b0, 32'h0000_0000, 0);
      u_iss.issue(ADD_CARRY_FLAGSET, 4'h6, 4'h7, 4'h6, 1'b1, 1'b0, 32'h0000_0000, 0);
      u_iss.idle();
      if (u_iss.timedOut) begin
         mismatches++;
         test_done();
      end
      repeat (3) @(posedge sys_clk);
      regRead(8'h18, rd);
      chkWord("carry word", 32'h0000_0001, rd);
      regRead(8'h10, rd);
      chkWord("low word", 32'h0000_0000, rd);
      runOp(ald_op_type'(4'hC), 4'h1, 4'h2, 4'h3, 1'b0, 1'b0, 32'h0000_0000, 0);
      chkNib("illegal", 4'h1, {3'b000, gotIll});
      chkWord("held result", 32'h0000_0001, gotData);
      regRead(`ALD_STATUS_ADDR, rd);
      chkWord("status", 32'h0000_0002, rd);
      regRead(8'h0C, rd);
      chkWord("kept reg", 32'hFFFF_F080, rd);
      regWrite(8'h34, 32'h0000_2000);
      regWrite(8'h3C, 32'h0000_1000);
      runOp(SUM_OP, 4'hD, 4'h0, 4'hD, 1'b1, 1'b1, 32'h0000_01FC, 0);
      chkWord("stack adjust", 32'h0000_21FC, gotData);
      runOp(SUM_OP, 4'hF, 4'h0, 4'h2, 1'b0, 1'b1, 32'h0000_03FC, 0);
      chkWord("pc offset", 32'h0000_13FC, gotData);
      regRead(`ALD_STATUS_ADDR, rd);
      chkWord("status clear", 32'h0000_0000, rd);
      test_done();
   end
endmodule : ald_datapath_tb

`default_nettype wire

// ---- tb/ald_issuer.sv ----
// Instruction issuer model that requests operations from the datapath
`timescale 1ns/1ps
`default_nettype none

module ald_issuer (
   // Clock and handshake
   input wire logic sys_clk,
   input wire logic opReady,
   // Operation request
   output logic opValid,
   output var ald_pkg::ald_op_type opCode,
   output logic [3:0] firstReg,
   output logic [3:0] secondReg,
   output logic [3:0] dstReg,
   output logic dstOmit,
   output logic useImm,
   output logic [31:0] immValue
);
   import ald_pkg::*;

   bit timedOut;

   initial begin
      timedOut = 1'b0;
      opValid = 1'b0;
      opCode = SUM_OP;
      firstReg = 4'h0;
      secondReg = 4'h0;
      dstReg = 4'h0;
      dstOmit = 1'b0;
      useImm = 1'b0;
      immValue = 32'h0000_0000;
   end

   // ==========================================
   // Request held until the edge that takes it
   task automatic issue(input ald_op_type op, input logic [3:0] f, s, d, input logic om, im,
                        input logic [31:0] iv, input int gap);
      int n;
      repeat (gap) @(posedge sys_clk);
      opValid <= 1'b1;
      opCode <= op;
      firstReg <= f;
      secondReg <= s;
      dstReg <= d;
      dstOmit <= om;
      useImm <= im;
      immValue <= iv;
      n = 0;
      #1;
      while (!opReady && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (!opReady) begin
         timedOut = 1'b1;
      end
      @(posedge sys_clk);
   endtask : issue

   // Released request: opCode, firstReg and immValue show junk
   task automatic idle();
      opValid <= 1'b0;
      opCode <= ald_op_type'(~opCode);
      firstReg <= ~firstReg;
      immValue <= ~immValue;
   endtask : idle
endmodule : ald_issuer

`default_nettype wire
